// ===== rtl/ter_pkg.sv
package ter_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_TRAP_WDOG_CTRL = 6'h34;
  localparam logic [5:0] ADDR_EXT_IRQ_CTRL   = 6'h37;
  localparam logic [5:0] ADDR_EN_LOW         = 6'h3A;
  localparam logic [5:0] ADDR_EN_HIGH        = 6'h3B;
  localparam logic [5:0] ADDR_LATCH_LOW      = 6'h3C;
  localparam logic [5:0] ADDR_LATCH_HIGH     = 6'h3D;
  // Field positions
  localparam int TRAP_MODE_BIT  = 3;
  localparam int RAM_TRAP_BIT   = 4;
  localparam int EDGE_ONE_BIT   = 2;
  localparam int PIN_FUNC_BIT   = 6;
  localparam int FILT_SEL_BIT   = 7;
  // Reset values and last SFR address
  localparam logic [7:0] EXT_IRQ_CTRL_RST = 8'h00;
  localparam logic [5:0] SFR_LAST         = 6'h3F;
  localparam logic [15:0] RESET_VECTOR    = 16'hFFFE;
  // Filter thresholds in fc periods: midway between reject and accept for zero, three quarters of midway for one and two
  localparam int FC_REJ_ZERO  = 2;
  localparam int FC_ACC_ZERO  = 7;
  localparam int FC_REJ_ONE_A = 15;
  localparam int FC_ACC_ONE_A = 49;
  localparam int FC_REJ_ONE_B = 63;
  localparam int FC_ACC_ONE_B = 193;
  localparam int FC_REJ_TWO   = 7;
  localparam int FC_ACC_TWO   = 25;
  localparam logic [7:0] THR_ZERO  = 8'((FC_REJ_ZERO + FC_ACC_ZERO) / 2);
  localparam logic [7:0] THR_ONE_A = 8'((FC_REJ_ONE_A + FC_ACC_ONE_A) / 2 - 8);
  localparam logic [7:0] THR_ONE_B = 8'((FC_REJ_ONE_B + FC_ACC_ONE_B) / 2 - 32);
  localparam logic [7:0] THR_TWO   = 8'((FC_REJ_TWO + FC_ACC_TWO) / 2 - 4);
  localparam logic [7:0] THR_SLOW  = 8'h02;
  // Reset timing in fc periods (clock_in runs at fc)
  localparam int FC_EXT_RST_MIN = 12;
  localparam int FC_RST_OUT     = 16;
  localparam logic [3:0] EXT_RST_CYC = 4'(FC_EXT_RST_MIN);
  localparam logic [4:0] RST_OUT_CYC = 5'(FC_RST_OUT);
endpackage

// ===== rtl/trap_extirq_reset_unit.sv
`timescale 1ns/1ps
module ter_trap_extirq_reset_unit #(
  parameter logic [15:0] RAM_FIRST = 16'h0040,
  parameter logic [15:0] RAM_LAST  = 16'h023F
) (
  // Clock and power-on reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [5:0]  sfr_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  output logic      [7:0]  sfr_rdata_out,
  // Processor side
  input  wire logic        undefined_opcode_in,
  input  wire logic        fetch_in,
  input  wire logic [15:0] fetch_addr_in,
  input  wire logic [4:0]  irq_accept_in,
  input  wire logic        low_clock_mode_in,
  output logic             undefined_opcode_trap_out,
  output logic             fetch_address_trap_irq_out,
  output logic      [4:0]  ext_irq_request_out,
  output logic             irq_zero_port_mode_out,
  // Clock control and watchdog
  input  wire logic        high_osc_enable_in,
  input  wire logic        low_osc_enable_in,
  input  wire logic        system_clock_select_in,
  input  wire logic        watchdog_reset_in,
  output logic             watchdog_enable_out,
  output logic             prescaler_clear_out,
  // Pins: zero, one, two, three, five, then low_freq_clock
  input  wire logic [4:0]  ext_irq_pin_in,
  input  wire logic        low_freq_clock_in,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  // Chip reset and restart
  output logic             device_reset_out,
  output logic             start_fetch_out,
  output logic      [15:0] start_vector_out
);

  typedef struct packed {
    logic [6:0]      s1;
    logic [6:0]      s2;
    logic            fs_prev;
    logic [4:0]      flt;
    logic [4:0][7:0] cnt;
    logic [4:0]      latch;
    logic [4:0]      enable;
    logic            master;
    logic [7:0]      ext_ctrl;
    logic            ram_sel;
    logic            trap_reset_mode;
    logic [3:0]      ext_low_cnt;
    logic [4:0]      rst_cnt;
    logic            dev_rst;
    logic [7:0]      rdata;
    logic            und_trap;
    logic            atrap_irq;
    logic [4:0]      req;
  } ter_state_s;

  ter_state_s st;
  ter_state_s next_st;
  logic [1:0] rst_sync;
  logic       rstn;

  // Noise filter length for a channel
  function automatic logic [7:0] ter_thr(input int ch, input logic sel, input logic slow);
    logic [7:0] t;
    t = ter_pkg::THR_ZERO;
    if (slow) t = ter_pkg::THR_SLOW;
    else if (ch == 1) t = sel ? ter_pkg::THR_ONE_A : ter_pkg::THR_ONE_B;
    else if (ch == 2 || ch == 3) t = ter_pkg::THR_TWO;
    return t;
  endfunction

  // Channel bits laid out in the low and high register images
  function automatic logic [7:0] ter_low_img(input logic [4:0] v, input logic b0);
    return {v[2], 1'b0, v[1], v[0], 3'h0, b0};
  endfunction
  function automatic logic [7:0] ter_high_img(input logic [4:0] v);
    return {v[4], v[3], 6'h00};
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  always_comb begin
    logic       tick;
    logic       rising;
    logic [4:0] edge_hit;
    logic       trapped;
    logic       clk_stop;
    logic       ext_rst;
    logic [7:0] thr;
    tick     = 1'b1;
    rising   = 1'b0;
    thr      = 8'h00;
    next_st  = st;
    edge_hit = 5'h00;
    // Pin synchronisers
    next_st.s1      = {low_freq_clock_in, reset_pin_in, ext_irq_pin_in};
    next_st.s2      = st.s1;
    next_st.fs_prev = st.s2[6];
    tick = low_clock_mode_in ? (st.s2[6] & ~st.fs_prev) : 1'b1;
    // Sampling filters and edge detect
    for (int i = 0; i < 5; i++) begin
      thr = ter_thr(i, st.ext_ctrl[ter_pkg::FILT_SEL_BIT], low_clock_mode_in);
      if (st.s2[i] == st.flt[i]) begin
        next_st.cnt[i] = 8'h00;
      end else if (tick) begin
        if (st.cnt[i] + 8'h01 >= thr) begin
          next_st.flt[i] = st.s2[i];
          next_st.cnt[i] = 8'h00;
          rising = st.s2[i];
          if (i >= 1 && i <= 3) begin
            edge_hit[i] = (rising == st.ext_ctrl[ter_pkg::EDGE_ONE_BIT + i - 1]);
          end else begin
            edge_hit[i] = ~rising;
          end
        end else begin
          next_st.cnt[i] = st.cnt[i] + 8'h01;
        end
      end
    end
    edge_hit[0] = edge_hit[0] & st.ext_ctrl[ter_pkg::PIN_FUNC_BIT];
    // Traps on instruction fetch
    next_st.und_trap = undefined_opcode_in;
    trapped = fetch_in && (fetch_addr_in <= {10'h000, ter_pkg::SFR_LAST} ||
              (st.ram_sel && fetch_addr_in >= RAM_FIRST && fetch_addr_in <= RAM_LAST));
    next_st.atrap_irq = trapped & ~st.trap_reset_mode;
    // Reset sources and output pulse
    clk_stop = (~high_osc_enable_in & ~low_osc_enable_in) |
               (~high_osc_enable_in & ~system_clock_select_in) |
               (~low_osc_enable_in & system_clock_select_in);
    if ((trapped & st.trap_reset_mode) | watchdog_reset_in | clk_stop) begin
      next_st.rst_cnt = ter_pkg::RST_OUT_CYC;
    end else if (st.rst_cnt != 5'h00) begin
      next_st.rst_cnt = st.rst_cnt - 5'h01;
    end
    if (st.s2[5]) begin
      next_st.ext_low_cnt = 4'h0;
    end else if (st.ext_low_cnt != ter_pkg::EXT_RST_CYC) begin
      next_st.ext_low_cnt = st.ext_low_cnt + 4'h1;
    end
    ext_rst = (next_st.ext_low_cnt == ter_pkg::EXT_RST_CYC);
    next_st.dev_rst = ext_rst | (next_st.rst_cnt != 5'h00);
    // Latches: set wins over clear
    next_st.latch = st.latch & ~irq_accept_in;
    if (sfr_wr_in && sfr_addr_in == ter_pkg::ADDR_LATCH_LOW) begin
      next_st.latch[2:0] = next_st.latch[2:0] & {sfr_wdata_in[7], sfr_wdata_in[5:4]};
    end
    if (sfr_wr_in && sfr_addr_in == ter_pkg::ADDR_LATCH_HIGH) begin
      next_st.latch[4:3] = next_st.latch[4:3] & sfr_wdata_in[7:6];
    end
    next_st.latch = next_st.latch | edge_hit;
    // Register writes
    if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        ter_pkg::ADDR_TRAP_WDOG_CTRL: begin
          next_st.trap_reset_mode = sfr_wdata_in[ter_pkg::TRAP_MODE_BIT];
          next_st.ram_sel         = sfr_wdata_in[ter_pkg::RAM_TRAP_BIT];
        end
        ter_pkg::ADDR_EXT_IRQ_CTRL: next_st.ext_ctrl = sfr_wdata_in;
        ter_pkg::ADDR_EN_LOW: begin
          next_st.master    = sfr_wdata_in[0];
          next_st.enable[0] = sfr_wdata_in[4];
          next_st.enable[1] = sfr_wdata_in[5];
          next_st.enable[2] = sfr_wdata_in[7];
        end
        ter_pkg::ADDR_EN_HIGH: next_st.enable[4:3] = sfr_wdata_in[7:6];
        default: ;
      endcase
    end
    // Register reads
    next_st.rdata = 8'h00;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        ter_pkg::ADDR_EXT_IRQ_CTRL: next_st.rdata = st.ext_ctrl;
        ter_pkg::ADDR_EN_LOW:       next_st.rdata = ter_low_img(st.enable, st.master);
        ter_pkg::ADDR_EN_HIGH:      next_st.rdata = ter_high_img(st.enable);
        ter_pkg::ADDR_LATCH_LOW:    next_st.rdata = ter_low_img(st.latch, 1'b0);
        ter_pkg::ADDR_LATCH_HIGH:   next_st.rdata = ter_high_img(st.latch);
        default:                    next_st.rdata = 8'h00;
      endcase
    end
    // Chip reset clears interrupt state
    if (st.dev_rst) begin
      next_st.master          = 1'b0;
      next_st.enable          = 5'h00;
      next_st.latch           = 5'h00;
      next_st.ext_ctrl        = ter_pkg::EXT_IRQ_CTRL_RST;
      next_st.ram_sel         = 1'b0;
      next_st.trap_reset_mode = 1'b1;
    end
    next_st.req = next_st.latch & next_st.enable & {5{next_st.master}};
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      st                 <= '0;
      st.s1              <= 7'h7F;
      st.s2              <= 7'h7F;
      st.flt             <= 5'h1F;
      st.trap_reset_mode <= 1'b1;
      st.dev_rst         <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  logic dev_rst_prev;
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      dev_rst_prev    <= 1'b1;
      start_fetch_out <= 1'b0;
    end else begin
      dev_rst_prev    <= st.dev_rst;
      start_fetch_out <= dev_rst_prev & ~st.dev_rst;
    end
  end

  assign sfr_rdata_out              = st.rdata;
  assign undefined_opcode_trap_out  = st.und_trap;
  assign fetch_address_trap_irq_out = st.atrap_irq;
  assign ext_irq_request_out        = st.req;
  assign irq_zero_port_mode_out     = ~st.ext_ctrl[ter_pkg::PIN_FUNC_BIT];
  assign watchdog_enable_out        = st.dev_rst | st.trap_reset_mode;
  assign prescaler_clear_out        = st.dev_rst;
  assign reset_pin_out              = 1'b0;
  assign reset_pin_oe_out           = (st.rst_cnt != 5'h00);
  assign device_reset_out           = st.dev_rst;
  assign start_vector_out           = ter_pkg::RESET_VECTOR;

endmodule // ter_trap_extirq_reset_unit

// ===== tb/ter_props.sv
`timescale 1ns/1ps
module ter_props (
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       rstn_in,
  // Observed ports
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       undefined_opcode_in,
  input wire logic       undefined_opcode_trap_out,
  input wire logic       fetch_in,
  input wire logic       fetch_address_trap_irq_out,
  input wire logic [4:0] ext_irq_request_out,
  input wire logic       irq_zero_port_mode_out,
  input wire logic       high_osc_enable_in,
  input wire logic       low_osc_enable_in,
  input wire logic       system_clock_select_in,
  input wire logic       watchdog_reset_in,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_clk_stop;
    (!high_osc_enable_in && !low_osc_enable_in) ||
    (!high_osc_enable_in && !system_clock_select_in) ||
    (!low_osc_enable_in && system_clock_select_in);
  endsequence
  sequence s_out_start;
    $rose(reset_pin_oe_out);
  endsequence
  undef_trap_a: assert property (undefined_opcode_in |=> undefined_opcode_trap_out)
    else $error("undefined opcode trap missing");
  trap_irq_a: assert property (fetch_address_trap_irq_out |-> $past(fetch_in))
    else $error("fetch trap without fetch");
  pin_drive_a: assert property (reset_pin_oe_out |-> !reset_pin_out)
    else $error("reset pin not driven low");
  clk_stop_a: assert property (s_clk_stop |-> ##[1:2] reset_pin_oe_out)
    else $error("clock stop gave no reset");
  wdog_reset_a: assert property (watchdog_reset_in |=> reset_pin_oe_out)
    else $error("watchdog reset not driven");
  rst_pulse_a: assert property (s_out_start |-> reset_pin_oe_out [*8])
    else $error("reset output pulse too short");
  rdata_idle_a: assert property (!$past(sfr_rd_in) |-> sfr_rdata_out == 8'h00)
    else $error("read data without read");
  zero_port_a: assert property ($rose(ext_irq_request_out[0]) |-> !irq_zero_port_mode_out)
    else $error("zero request in port mode");
endmodule // ter_props
bind ter_trap_extirq_reset_unit ter_props ter_props_i (.clock_in, .rstn_in, .sfr_rd_in,
  .sfr_rdata_out, .undefined_opcode_in, .undefined_opcode_trap_out, .fetch_in,
  .fetch_address_trap_irq_out, .ext_irq_request_out, .irq_zero_port_mode_out,
  .high_osc_enable_in, .low_osc_enable_in, .system_clock_select_in, .watchdog_reset_in,
  .reset_pin_out, .reset_pin_oe_out);

// ===== tb/ter_pin_model.sv
`timescale 1ns/1ps
module ter_pin_model (
  // Clock
  input  wire logic       clock_in,
  // Device pin drive
  input  wire logic       dev_drive_in,
  input  wire logic       dev_level_in,
  // Pin levels
  output logic      [4:0] irq_pin_out,
  output wire logic       reset_pin_out
);
  logic hold_low = 1'b0;
  initial irq_pin_out = 5'h1F;
  // Pulled up unless someone pulls low
  assign reset_pin_out = (dev_drive_in ? dev_level_in : 1'b1) & !hold_low;
  task automatic pulse(input int ch, input int len);
    irq_pin_out[ch] <= 1'b0;
    repeat (len) @(posedge clock_in);
    irq_pin_out[ch] <= 1'b1;
  endtask
  task automatic hold_reset(input int len);
    hold_low <= 1'b1;
    repeat (len) @(posedge clock_in);
    hold_low <= 1'b0;
  endtask
endmodule // ter_pin_model

// ===== tb/tb_trap_extirq_reset_unit.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module tb_trap_extirq_reset_unit;
  logic clock_in = 0, rstn_in = 0, wr = 0, rd = 0, undef = 0, fetch = 0, lowm = 0;
  logic hi = 1, lo = 1, sel = 0, wdog = 0, lfc = 0, oe, rpo, dres, ppm;
  logic [5:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic [15:0] faddr = 0;
  logic [4:0] acc = 0, pins, req;
  wire rpin;
  int error_cnt = 0, checks = 0;
  always #12.5 clock_in = ~clock_in;
  ter_pin_model ter_pin_model_i (.clock_in, .dev_drive_in(oe), .dev_level_in(rpo),
    .irq_pin_out(pins), .reset_pin_out(rpin));
  ter_trap_extirq_reset_unit ter_trap_extirq_reset_unit_i (.clock_in, .rstn_in,
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_rdata_out(rdata), .undefined_opcode_in(undef), .fetch_in(fetch),
    .fetch_addr_in(faddr), .irq_accept_in(acc), .low_clock_mode_in(lowm),
    .undefined_opcode_trap_out(), .fetch_address_trap_irq_out(), .ext_irq_request_out(req),
    .irq_zero_port_mode_out(ppm), .high_osc_enable_in(hi), .low_osc_enable_in(lo),
    .system_clock_select_in(sel), .watchdog_reset_in(wdog), .watchdog_enable_out(),
    .prescaler_clear_out(), .ext_irq_pin_in(pins), .low_freq_clock_in(lfc),
    .reset_pin_in(rpin), .reset_pin_out(rpo), .reset_pin_oe_out(oe),
    .device_reset_out(dres), .start_fetch_out(), .start_vector_out());
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock_in); wr <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clock_in); rd <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge clock_in);
  endtask
  task automatic settle;
    for (int i = 0; i < 300 && (dres !== 1'b0 || oe !== 1'b0); i++) @(posedge clock_in);
    #1 `CHK(dres, 1'b0)
    @(posedge clock_in);
  endtask
  task automatic do_fetch(input logic [15:0] a, input logic e);
    fetch <= 1'b1; faddr <= a;
    @(posedge clock_in); fetch <= 1'b0;
    #1 `CHK(ter_trap_extirq_reset_unit_i.fetch_address_trap_irq_out, e)
    @(posedge clock_in);
  endtask
  task automatic test_traps;
    undef <= 1'b1;
    @(posedge clock_in); undef <= 1'b0;
    #1 `CHK(ter_trap_extirq_reset_unit_i.undefined_opcode_trap_out, 1'b1)
    @(posedge clock_in);
    rd_chk(ter_pkg::ADDR_TRAP_WDOG_CTRL, 8'h00);
    fetch <= 1'b1; faddr <= 16'h0010;
    @(posedge clock_in); fetch <= 1'b0;
    @(posedge clock_in); #1 `CHK(oe, 1'b1)
    settle();
    rd_chk(ter_pkg::ADDR_EN_LOW, 8'h00);
    wr_reg(ter_pkg::ADDR_TRAP_WDOG_CTRL, 8'h00);
    do_fetch(16'h0100, 1'b0);
    do_fetch(16'h0010, 1'b1);
    wr_reg(ter_pkg::ADDR_TRAP_WDOG_CTRL, 8'h10);
    do_fetch(16'h0100, 1'b1);
  endtask
  task automatic test_zero;
    wr_reg(ter_pkg::ADDR_EN_LOW, 8'h91);
    #1 `CHK(ppm, 1'b1)
    ter_pin_model_i.pulse(0, 10);
    repeat (15) @(posedge clock_in);
    #1 `CHK(req[0], 1'b0)
    wr_reg(ter_pkg::ADDR_EN_LOW, 8'h00);
    wr_reg(ter_pkg::ADDR_EXT_IRQ_CTRL, 8'h48);
    wr_reg(ter_pkg::ADDR_EN_LOW, 8'h91);
    rd_chk(ter_pkg::ADDR_EXT_IRQ_CTRL, 8'h48);
    ter_pin_model_i.pulse(0, 1);
    repeat (15) @(posedge clock_in);
    #1 `CHK(req[0], 1'b0)
    ter_pin_model_i.pulse(0, 7);
    repeat (8) @(posedge clock_in);
    #1 `CHK(req[0], 1'b1)
    acc <= 5'h01;
    @(posedge clock_in); acc <= 5'h00;
    repeat (2) @(posedge clock_in);
    #1 `CHK(req[0], 1'b0)
    ter_pin_model_i.pulse(2, 30);
    #1 `CHK(req[2], 1'b0)
    repeat (31) @(posedge clock_in);
    #1 `CHK(req[2], 1'b1)
  endtask
  task automatic test_resets;
    hi <= 1'b0;
    @(posedge clock_in); hi <= 1'b1;
    @(posedge clock_in); #1 `CHK(oe, 1'b1)
    settle();
    wdog <= 1'b1;
    @(posedge clock_in); wdog <= 1'b0;
    #1 `CHK(oe, 1'b1)
    settle();
    ter_pin_model_i.hold_reset(14);
    #1 `CHK(dres, 1'b1)
    settle();
    rd_chk(ter_pkg::ADDR_EXT_IRQ_CTRL, ter_pkg::EXT_IRQ_CTRL_RST);
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    settle();
    test_traps();
    test_zero();
    test_resets();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    error_cnt++;
    finish_test();
  end
endmodule // tb_trap_extirq_reset_unit
